// file: inc/dsr_pkg.sv
// package for the dual serial register access block
package dsr_pkg;
  localparam int DATA_W = 8;
  localparam int PTR_W = 3;
  localparam int NUM_CH = 2;
  localparam int CH_B = 1;
  // register pointer codes
  localparam logic [2:0] PTR_CMD = 3'h0;
  localparam logic [2:0] PTR_IRQ_MODE = 3'h1;
  localparam logic [2:0] PTR_VECTOR = 3'h2;
  localparam logic [2:0] PTR_RX_PARAM = 3'h3;
  localparam logic [2:0] PTR_SHARED = 3'h4;
  localparam logic [2:0] PTR_TX_PARAM = 3'h5;
  // command byte fields
  localparam int PTR_LSB = 0;
  localparam int CMD_LSB = 3;
  localparam int CMD_W = 3;
  localparam logic [2:0] CMD_NULL = 3'h0;
  localparam logic [2:0] CMD_CH_RESET = 3'h3;
  // write register reset value
  localparam logic [7:0] REG_RST = 8'h00;
  // modified vector: bits 1..3 replaced by the pending condition code
  localparam int VEC_MOD_LSB = 1;
  localparam int VEC_MOD_W = 3;
  localparam logic [2:0] VEC_NO_IRQ = 3'h3;

  // one host access as seen at the pins
  typedef struct packed {
    logic wr;
    logic rd;
    logic ch_b;
    logic ctrl;
    logic [7:0] data;
  } dsr_access_s;

  // per-channel status inputs
  typedef struct packed {
    logic [7:0] primary;
    logic [7:0] rx_err;
  } dsr_status_s;

  // per-channel write register contents
  typedef struct packed {
    logic [7:0] irq_mode;
    logic [7:0] rx_param;
    logic [7:0] shared_param;
    logic [7:0] tx_param;
  } dsr_config_s;
endpackage

// file: rtl/dsr_channel.sv
// one channel: pointer, command byte decode and write registers
`timescale 1ns/1ps
module dsr_channel
  import dsr_pkg::*;
#(
  parameter bit HAS_VECTOR = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ctrl_wr,
  input wire logic ctrl_rd,
  input wire logic [7:0] wdata,
  output logic [2:0] ptr,
  output dsr_config_s cfg,
  output logic [7:0] vector_base,
  output logic chan_reset,
  output logic [2:0] basic_cmd
);
  logic [2:0] ptr_ff;
  logic [2:0] nxt_ptr;
  logic is_reset_cmd;

  assign ptr = ptr_ff;
  assign basic_cmd = wdata[CMD_LSB +: CMD_W];
  assign is_reset_cmd = (ptr_ff == PTR_CMD) && (basic_cmd == CMD_CH_RESET);
  // pulse valid in the write cycle of a reset command
  assign chan_reset = ctrl_wr && is_reset_cmd;

  // pointer walk: a command byte may aim it, any pointed access returns it
  always_comb begin
    nxt_ptr = ptr_ff;
    if (ctrl_wr) begin
      if (ptr_ff != PTR_CMD) begin
        nxt_ptr = PTR_CMD;
      end else if (is_reset_cmd) begin
        nxt_ptr = PTR_CMD;
      end else begin
        nxt_ptr = wdata[PTR_LSB +: PTR_W];
      end
    end else if (ctrl_rd) begin
      nxt_ptr = PTR_CMD;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_ff <= PTR_CMD;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end

  // write registers; a channel reset clears the channel configuration
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg <= '0;
    end else if (chan_reset) begin
      cfg <= '0;
    end else if (ctrl_wr) begin
      case (ptr_ff)
        PTR_IRQ_MODE: cfg.irq_mode <= wdata;
        PTR_RX_PARAM: cfg.rx_param <= wdata;
        PTR_SHARED: cfg.shared_param <= wdata;
        PTR_TX_PARAM: cfg.tx_param <= wdata;
        default: cfg <= cfg;
      endcase
    end
  end

  // vector base exists only where the parameter asks; it survives channel reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vector_base <= REG_RST;
    end else if (HAS_VECTOR && ctrl_wr && ptr_ff == PTR_VECTOR) begin
      vector_base <= wdata;
    end
  end

  ptr_ret_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_wr && ptr_ff != PTR_CMD) |=> ptr_ff == PTR_CMD) else $error("pointer not returned");
  rst_ptr_a: assert property (@(posedge clk) disable iff (sys_rst)
    chan_reset |=> ptr_ff == PTR_CMD) else $error("reset left pointer set");
  ptr_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_wr && ptr_ff == PTR_CMD && !is_reset_cmd) |=> ptr_ff == $past(wdata[PTR_LSB +: PTR_W]))
    else $error("pointer not taken");
  wr_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_wr && ptr_ff == PTR_TX_PARAM) |=> cfg.tx_param == $past(wdata)) else $error("tx param lost");
endmodule

// file: rtl/dsr_top.sv
// two-channel serial controller register access: pin decode and readback
`timescale 1ns/1ps
module dsr_top
  import dsr_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic chan_sel_b,
  input wire logic ctrl_sel,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_rdata_valid,
  input wire dsr_status_s [1:0] ch_status,
  input wire logic irq_pending,
  input wire logic [2:0] irq_cond,
  output dsr_config_s [1:0] ch_config,
  output logic [7:0] vector_base,
  output logic [1:0] chan_reset,
  output logic [1:0] data_wr,
  output logic [1:0] data_rd,
  output logic [7:0] data_wdata,
  input wire logic [15:0] data_rdata
);
  dsr_access_s acc;
  logic [1:0] ctrl_wr;
  logic [1:0] ctrl_rd;
  logic [2:0] ptr [2];
  logic [7:0] vec_b [2];
  logic [7:0] mod_vector;
  logic [7:0] nxt_rdata;
  logic [7:0] rdata_ff;
  logic rvalid_ff;

  // access bundle from host pins; same clock, no synchroniser needed
  assign acc = '{wr: host_wr, rd: host_rd, ch_b: chan_sel_b, ctrl: ctrl_sel, data: host_wdata};

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      // route by channel select and control/data select
      assign ctrl_wr[g] = acc.wr && acc.ctrl && (acc.ch_b == (g == CH_B));
      assign ctrl_rd[g] = acc.rd && acc.ctrl && (acc.ch_b == (g == CH_B));
      assign data_wr[g] = acc.wr && !acc.ctrl && (acc.ch_b == (g == CH_B));
      assign data_rd[g] = acc.rd && !acc.ctrl && (acc.ch_b == (g == CH_B));
      dsr_channel #(.HAS_VECTOR(g == CH_B)) u_ch (
        .clk(clk),
        .sys_rst(sys_rst),
        .ctrl_wr(ctrl_wr[g]),
        .ctrl_rd(ctrl_rd[g]),
        .wdata(acc.data),
        .ptr(ptr[g]),
        .cfg(ch_config[g]),
        .vector_base(vec_b[g]),
        .chan_reset(chan_reset[g]),
        .basic_cmd()
      );
    end
  endgenerate

  assign vector_base = vec_b[CH_B];
  assign data_wdata = acc.data;

  // vector as modified by the pending condition; idle code when nothing pends
  always_comb begin
    mod_vector = vec_b[CH_B];
    mod_vector[VEC_MOD_LSB +: VEC_MOD_W] = irq_pending ? irq_cond : VEC_NO_IRQ;
  end

  // read mux; unpointed or unknown pointer gives primary status
  always_comb begin
    nxt_rdata = REG_RST;
    if (acc.rd && acc.ctrl) begin
      case (ptr[acc.ch_b])
        PTR_IRQ_MODE: nxt_rdata = ch_status[acc.ch_b].rx_err;
        PTR_VECTOR: nxt_rdata = acc.ch_b ? mod_vector : ch_status[0].primary;
        default: nxt_rdata = ch_status[acc.ch_b].primary;
      endcase
    end else if (acc.rd) begin
      // data bytes sit side by side, channel a low; the channel select picks one
      nxt_rdata = data_rdata[acc.ch_b * DATA_W +: DATA_W];
    end
  end

  // read data registered; valid the cycle after the read strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= REG_RST;
    end else if (acc.rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= acc.rd;
    end
  end

  assign host_rdata = rdata_ff;
  assign host_rdata_valid = rvalid_ff;

  // a control write or read on one channel while its pointer aims at register p
  sequence pointed_wr_s(int ch, logic [2:0] p);
    ctrl_wr[ch] && ptr[ch] == p;
  endsequence

  sequence pointed_rd_s(int ch, logic [2:0] p);
    ctrl_rd[ch] && ptr[ch] == p;
  endsequence

  // first step of a two-byte access: a plain command byte that aims the pointer
  // kept as sequences so each check reads as the steps the host takes
  sequence ptr_byte_s(int ch);
    ctrl_wr[ch] && ptr[ch] == PTR_CMD && host_wdata[CMD_LSB +: CMD_W] != CMD_CH_RESET;
  endsequence

  // status reads, answered one edge after the strobe
  rd_err_a: assert property (@(posedge clk) disable iff (sys_rst)
    (host_rd && ctrl_sel && ptr[chan_sel_b] == PTR_IRQ_MODE)
    |=> host_rdata_valid && host_rdata == $past(ch_status[chan_sel_b].rx_err))
    else $error("error status read wrong");
  rd_pri_a: assert property (@(posedge clk) disable iff (sys_rst)
    (host_rd && ctrl_sel && ptr[chan_sel_b] == PTR_CMD)
    |=> host_rdata == $past(ch_status[chan_sel_b].primary)) else $error("primary status read wrong");
  rvalid_a: assert property (@(posedge clk) disable iff (sys_rst)
    host_rdata_valid == $past(host_rd)) else $error("read valid out of step");

  // modified vector: condition code in its field, the written base elsewhere
  vec_mod_a: assert property (@(posedge clk) disable iff (sys_rst)
    pointed_rd_s(CH_B, PTR_VECTOR) ##0 irq_pending
    |=> host_rdata[VEC_MOD_LSB +: VEC_MOD_W] == $past(irq_cond)) else $error("vector not modified");
  vec_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    pointed_rd_s(CH_B, PTR_VECTOR) ##0 !irq_pending
    |=> host_rdata[VEC_MOD_LSB +: VEC_MOD_W] == VEC_NO_IRQ) else $error("idle vector code wrong");
  vec_back_a: assert property (@(posedge clk) disable iff (sys_rst)
    pointed_rd_s(CH_B, PTR_VECTOR)
    |=> host_rdata[DATA_W-1:VEC_MOD_LSB+VEC_MOD_W] == $past(vector_base[DATA_W-1:VEC_MOD_LSB+VEC_MOD_W])
    && host_rdata[VEC_MOD_LSB-1:0] == $past(vector_base[VEC_MOD_LSB-1:0])) else $error("vector base lost");
  vec_rd_none_a: assert property (@(posedge clk) disable iff (sys_rst)
    pointed_rd_s(0, PTR_VECTOR)
    |=> host_rdata == $past(ch_status[0].primary)) else $error("channel a vector read wrong");

  // both selects route every data access to the data path, never to a control path
  sel_a: assert property (@(posedge clk) disable iff (sys_rst)
    (host_wr && !ctrl_sel) |-> (data_wr != 2'h0) && (ctrl_wr == 2'h0)) else $error("data path misrouted");
  sel_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
    (host_rd && !ctrl_sel) |-> (data_rd != 2'h0) && (ctrl_rd == 2'h0)) else $error("data read misrouted");
  data_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
    (host_rd && !ctrl_sel)
    |=> host_rdata == $past(data_rdata[chan_sel_b * DATA_W +: DATA_W])) else $error("data byte wrong");

  // pointer: aimed by a plain command byte, held until the access, then back
  ptr_aim_a: assert property (@(posedge clk) disable iff (sys_rst)
    ptr_byte_s(CH_B) |=> ptr[CH_B] == $past(host_wdata[PTR_LSB +: PTR_W])) else $error("pointer byte lost");
  ptr_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ptr[CH_B] != PTR_CMD && !ctrl_wr[CH_B] && !ctrl_rd[CH_B]) |=> $stable(ptr[CH_B]))
    else $error("pointer moved while idle");
  rd_ret_a: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_rd[0] |=> ptr[0] == PTR_CMD) else $error("channel a pointer kept after read");
  rd_ret_b_a: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_rd[CH_B] |=> ptr[CH_B] == PTR_CMD) else $error("channel b pointer kept after read");

  // each pointed write lands in its own register of the addressed channel, except a vector write on channel a, which lands nowhere
  irq_mode_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
    pointed_wr_s(CH_B, PTR_IRQ_MODE)
    |=> ch_config[CH_B].irq_mode == $past(host_wdata)) else $error("interrupt mode lost");
  rx_param_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
    pointed_wr_s(0, PTR_RX_PARAM)
    |=> ch_config[0].rx_param == $past(host_wdata)) else $error("rx param lost");
  tx_param_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
    pointed_wr_s(CH_B, PTR_TX_PARAM)
    |=> ch_config[CH_B].tx_param == $past(host_wdata)) else $error("tx param lost");
  shared_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
    pointed_wr_s(0, PTR_SHARED)
    |=> ch_config[0].shared_param == $past(host_wdata)) else $error("shared param lost");
  vec_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
    pointed_wr_s(CH_B, PTR_VECTOR)
    |=> vector_base == $past(host_wdata)) else $error("vector base not written");
  vec_absent_a: assert property (@(posedge clk) disable iff (sys_rst)
    pointed_wr_s(0, PTR_VECTOR)
    |=> $stable(ch_config[0]) && vec_b[0] == REG_RST) else $error("channel a took a vector");

  // setup moves only on a control write to its channel; reset command clears it
  cfg_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !ctrl_wr[0] |=> $stable(ch_config[0])) else $error("channel a config moved");
  cfg_hold_b_a: assert property (@(posedge clk) disable iff (sys_rst)
    !ctrl_wr[CH_B] |=> $stable(ch_config[CH_B])) else $error("channel b config moved");
  rst_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    chan_reset[0] |=> (ch_config[0] == '0) && $stable(vector_base)) else $error("reset command left setup");
endmodule

// file: tb/dsr_host.sv
// host processor model: drives pin-level control and data accesses
`timescale 1ns/1ps
module dsr_host (
  input wire logic clk,
  output logic host_wr,
  output logic host_rd,
  output logic chan_sel_b,
  output logic ctrl_sel,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic host_rdata_valid
);
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    chan_sel_b = 1'b0;
    ctrl_sel = 1'b0;
    host_wdata = 8'h00;
  end
  // one access; selects come with the strobe and are held to the taking edge
  task automatic acc(input logic w, input logic b, input logic c, input logic [7:0] d);
    @(posedge clk);
    #1;
    host_wr = w;
    host_rd = !w;
    chan_sel_b = b;
    ctrl_sel = c;
    host_wdata = d;
    @(posedge clk);
    #1;
    host_wr = 1'b0;
    host_rd = 1'b0;
    // released bus shows the inverse so stale data never looks valid
    host_wdata = ~d;
  endtask
  task automatic wr(input logic b, input logic c, input logic [7:0] d);
    acc(1'b1, b, c, d);
  endtask
  // read data and valid stand for the cycle after the taking edge
  task automatic rd(input logic b, input logic c, output logic [8:0] got);
    acc(1'b0, b, c, 8'h00);
    got = {host_rdata_valid, host_rdata};
  endtask
endmodule

// file: tb/tb_top.sv
// self-checking bench for the dual serial register access block
`timescale 1ns/1ps
module tb_top;
  import dsr_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic irq_pending = 1'b0;
  logic [2:0] irq_cond = 3'h0;
  logic host_wr, host_rd, chan_sel_b, ctrl_sel, host_rdata_valid;
  logic [7:0] host_wdata, host_rdata, vector_base, data_wdata, cb;
  logic [8:0] got;
  dsr_status_s [1:0] ch_status;
  dsr_config_s [1:0] ch_config;
  logic [1:0] chan_reset, data_wr, data_rd;
  logic [15:0] data_rdata = 16'hC35A;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int rst_seen = 0;
  int dw_seen = 0;
  int dra_seen = 0;
  int drb_seen = 0;
  assign ch_status = {16'h8112, 16'h4421};
  initial begin
    forever #2.5 clk = ~clk;
  end
  dsr_top dsr_top_i (.clk(clk), .sys_rst(sys_rst), .host_wr(host_wr), .host_rd(host_rd),
    .chan_sel_b(chan_sel_b), .ctrl_sel(ctrl_sel), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rdata_valid(host_rdata_valid), .ch_status(ch_status), .irq_pending(irq_pending),
    .irq_cond(irq_cond), .ch_config(ch_config), .vector_base(vector_base), .chan_reset(chan_reset),
    .data_wr(data_wr), .data_rd(data_rd), .data_wdata(data_wdata), .data_rdata(data_rdata));
  dsr_host dsr_host_i (.clk(clk), .host_wr(host_wr), .host_rd(host_rd), .chan_sel_b(chan_sel_b),
    .ctrl_sel(ctrl_sel), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rdata_valid(host_rdata_valid));
  // pulses seen on the edge that takes the access; hang guard too
  always @(posedge clk) begin
    cycles++;
    if (chan_reset === 2'b01) rst_seen++;
    if (data_wr === 2'b10 && data_wdata === 8'h3C) dw_seen++;
    if (data_rd === 2'b01) dra_seen++;
    if (data_rd === 2'b10) drb_seen++;
    if (cycles == 3000) begin
      errors++;
      finish_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] act);
    check_count++;
    if (act !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, act);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    dsr_host_i.rd(1'b0, 1'b1, got);
    chk("primary a", 9'h144, got);
    // pointer byte then value, every write register except the vector (pointer 2), both channels
    for (int c = 0; c < 2; c++) begin
      cb = 8'(c);
      for (int p = 1; p < 6; p++) begin
        if (p != 2) begin
          dsr_host_i.wr(c[0], 1'b1, 8'(p));
          dsr_host_i.wr(c[0], 1'b1, 8'(p * 16) | cb);
        end
      end
      chk("config", {8'h10 | cb, 8'h30 | cb, 8'h40 | cb, 8'h50 | cb}, ch_config[c]);
    end
    // vector register absent on channel a: nothing changes
    dsr_host_i.wr(1'b0, 1'b1, 8'h02);
    dsr_host_i.wr(1'b0, 1'b1, 8'hEE);
    chk("config a", 32'h10304050, ch_config[0]);
    chk("vector", 8'h00, vector_base);
    dsr_host_i.rd(1'b0, 1'b1, got);
    chk("primary a", 9'h144, got);
    // channel a has no modified vector: pointer 2 there still reads primary status
    dsr_host_i.wr(1'b0, 1'b1, 8'h02);
    dsr_host_i.rd(1'b0, 1'b1, got);
    chk("primary a", 9'h144, got);
    dsr_host_i.wr(1'b1, 1'b1, 8'h02);
    dsr_host_i.wr(1'b1, 1'b1, 8'hA5);
    chk("vector", 8'hA5, vector_base);
    dsr_host_i.wr(1'b1, 1'b1, 8'h02);
    dsr_host_i.rd(1'b1, 1'b1, got);
    chk("vector read", 9'h1A7, got);
    irq_pending = 1'b1;
    irq_cond = 3'h5;
    dsr_host_i.wr(1'b1, 1'b1, 8'h02);
    dsr_host_i.rd(1'b1, 1'b1, got);
    chk("vector read", 9'h1AB, got);
    dsr_host_i.wr(1'b1, 1'b1, 8'h01);
    dsr_host_i.rd(1'b1, 1'b1, got);
    chk("rx error b", 9'h112, got);
    dsr_host_i.rd(1'b1, 1'b1, got);
    chk("primary b", 9'h181, got);
    // channel reset command, then a single-byte pointer for the next write
    dsr_host_i.wr(1'b0, 1'b1, 8'h18);
    chk("reset pulse", 1, rst_seen);
    chk("config a", 32'h0, ch_config[0]);
    chk("config b", 32'h11314151, ch_config[1]);
    dsr_host_i.wr(1'b0, 1'b1, 8'h05);
    dsr_host_i.wr(1'b0, 1'b1, 8'h77);
    chk("config a", 32'h00000077, ch_config[0]);
    // data path routing by both selects
    dsr_host_i.wr(1'b1, 1'b0, 8'h3C);
    chk("data write", 1, dw_seen);
    dsr_host_i.rd(1'b0, 1'b0, got);
    chk("data a", 9'h15A, got);
    chk("data read a", 1, dra_seen);
    dsr_host_i.rd(1'b1, 1'b0, got);
    chk("data b", 9'h1C3, got);
    chk("data read b", 1, drb_seen);
    // external reset in mid-run must drop an aimed pointer and the setup
    dsr_host_i.wr(1'b1, 1'b1, 8'h03);
    @(posedge clk);
    #1;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    dsr_host_i.rd(1'b1, 1'b1, got);
    chk("primary b", 9'h181, got);
    chk("config b", 32'h0, ch_config[1]);
    chk("vector", 8'h00, vector_base);
    finish_test();
  end
endmodule
